//--- psclk_pkg.sv
package psclk_pkg;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CLOCK_DIVIDER_REGISTER  = 8'h00;  // clock_divider_register
  localparam logic [7:0] ADDR_MODDIS  = 8'h04;  // module_clock_disable
  localparam logic [7:0] ADDR_PSCTRL  = 8'h08;  // power-save command (write)
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;  // block state (read)

  // clock_divider_register fields
  localparam int RECOVER_BIT  = 15;
  localparam int RATIO_HI     = 14;
  localparam int RATIO_LO     = 12;
  localparam int SLOW_EN_BIT  = 11;
  localparam logic [2:0] RATIO_RST = 3'h0;   // 1:1
  localparam logic [15:0] CLOCK_DIVIDER_REGISTER_RST = 16'h0000;

  // Power-save command field
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_IDLE_BIT  = 1;

  // Peripheral count and presence mask
  localparam int NPERIPH = 16;
  localparam logic [NPERIPH-1:0] PRESENT_RST = 16'hFFFF;

  // Module-disable delay: one instruction cycle, in clocks
  localparam int INSTR_CYCLES = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PS_RUN   = 3'b001,
    PS_IDLE  = 3'b010,
    PS_SLEEP = 3'b100
  } psclk_state_e;

  // Clock-gate enables toward the core
  typedef struct packed {
    logic                cpu_clk_en;
    logic                sys_osc_en;
    logic                low_power_rc_oscillator_en;
    logic [NPERIPH-1:0]  periph_clk_en;
  } psclk_gates_s;

endpackage

//--- psclk_doze_div.sv
`timescale 1ns/1ps
// CPU clock enable divider for slow operation
module psclk_doze_div
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] ratio,
  input  wire logic       active,
  output logic            cpu_en
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [2:0] ratio_r;
  logic [2:0] ratio_nxt;

  // Terminal count for 2^ratio
  function automatic logic [7:0] term(input logic [2:0] r);
    term = 8'(({1'b0, 8'h01} << r) - 9'h001);
  endfunction

  // Count on peripheral clock, reload on ratio change
  always_comb
  begin
    ratio_nxt = ratio;
    if (!active || ratio != ratio_r || cnt_r == 8'h00)
      cnt_nxt = term(ratio);
    else
      cnt_nxt = cnt_r - 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r   <= 8'h00;
      ratio_r <= 3'h0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  // One enable every 2^ratio clocks, always in step with clk
  assign cpu_en = !active || (cnt_r == 8'h00 && ratio == ratio_r);

endmodule // psclk_doze_div

//--- psclk_ctrl.sv
`timescale 1ns/1ps
module psclk_ctrl
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  // AXI4-Lite slave
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // System
  input  wire logic                          irq_pending,
  input  wire logic                          wdt_timeout,
  input  wire logic                          wdt_enabled,
  input  wire logic                          failsafe_clock_monitor_enabled,
  input  wire logic [psclk_pkg::NPERIPH-1:0] periph_present,
  input  wire logic [psclk_pkg::NPERIPH-1:0] periph_wr_req,
  output psclk_pkg::psclk_gates_s            gates,
  output logic [psclk_pkg::NPERIPH-1:0]      periph_access_en,
  output logic                               wdt_clear,
  output logic                               irq_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0]                    clock_divider_register_r;
  logic [15:0]                    clock_divider_register_nxt;
  logic [psclk_pkg::NPERIPH-1:0]  moddis_r;
  logic [psclk_pkg::NPERIPH-1:0]  moddis_nxt;
  logic [psclk_pkg::NPERIPH-1:0]  moddis_eff_r;
  logic [psclk_pkg::NPERIPH-1:0]  moddis_eff_nxt;
  psclk_pkg::psclk_state_e        st_r;
  psclk_pkg::psclk_state_e        st_nxt;
  logic                           wdt_clr_r;
  logic                           wdt_clr_nxt;
  logic                           wake_r;
  logic                           wake_nxt;
  logic                           full_speed_r;
  logic                           full_speed_nxt;

  // AXI state
  logic                           aw_hold_r;
  logic                           aw_hold_nxt;
  logic [7:0]                     awaddr_r;
  logic [7:0]                     awaddr_nxt;
  logic                           w_hold_r;
  logic                           w_hold_nxt;
  logic [31:0]                    wdata_r;
  logic [31:0]                    wdata_nxt;
  logic [3:0]                     wstrb_r;
  logic [3:0]                     wstrb_nxt;
  logic                           bvalid_r;
  logic                           bvalid_nxt;
  logic [1:0]                     bresp_r;
  logic [1:0]                     bresp_nxt;
  logic                           rvalid_r;
  logic                           rvalid_nxt;
  logic [31:0]                    rdata_r;
  logic [31:0]                    rdata_nxt;
  logic [1:0]                     rresp_r;
  logic [1:0]                     rresp_nxt;

  logic                           wr_fire;
  logic                           slow_active;
  logic                           doze_en;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER) || (a == psclk_pkg::ADDR_MODDIS)
           || (a == psclk_pkg::ADDR_PSCTRL) || (a == psclk_pkg::ADDR_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channels, address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;

  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    awaddr_nxt  = awaddr_r;
    w_hold_nxt  = w_hold_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = addr_ok(awaddr_r) ? psclk_pkg::RESP_OKAY : psclk_pkg::RESP_SLVERR;
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  assign s_axi_arready = !rvalid_r;

  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = psclk_pkg::RESP_OKAY;
      case (s_axi_araddr)
        psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER: rdata_nxt = {16'h0000, clock_divider_register_r};
        psclk_pkg::ADDR_MODDIS: rdata_nxt = {16'h0000, moddis_r};
        psclk_pkg::ADDR_STATUS: rdata_nxt = {8'h00, moddis_eff_r, 2'h0,
                                             full_speed_r, 2'h0, st_r};
        psclk_pkg::ADDR_PSCTRL: rdata_nxt = 32'h0000_0000;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = psclk_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, power-save state and wake handling
  always_comb
  begin
    clock_divider_register_nxt     = clock_divider_register_r;
    moddis_nxt     = moddis_r;
    st_nxt         = st_r;
    wdt_clr_nxt    = 1'b0;
    wake_nxt       = 1'b0;
    full_speed_nxt = full_speed_r;
    if (wr_fire && awaddr_r == psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER)
      clock_divider_register_nxt = merge16(clock_divider_register_r, wdata_r, wstrb_r);
    if (wr_fire && awaddr_r == psclk_pkg::ADDR_MODDIS)
      moddis_nxt = merge16(moddis_r, wdata_r, wstrb_r) & periph_present;
    // Fresh enable of slow mode starts slow
    if (!clock_divider_register_r[psclk_pkg::SLOW_EN_BIT])
      full_speed_nxt = 1'b0;
    else if (irq_pending && clock_divider_register_r[psclk_pkg::RECOVER_BIT])
      full_speed_nxt = 1'b1;
    case (st_r)
      psclk_pkg::PS_RUN:
      begin
        // Entry completes first; coincident interrupt wakes next cycle
        if (wr_fire && awaddr_r == psclk_pkg::ADDR_PSCTRL
            && wstrb_r[0] && wdata_r[psclk_pkg::CMD_SLEEP_BIT])
        begin
          st_nxt      = psclk_pkg::PS_SLEEP;
          wdt_clr_nxt = 1'b1;
        end
        else if (wr_fire && awaddr_r == psclk_pkg::ADDR_PSCTRL
                 && wstrb_r[0] && wdata_r[psclk_pkg::CMD_IDLE_BIT])
        begin
          st_nxt      = psclk_pkg::PS_IDLE;
          wdt_clr_nxt = 1'b1;
        end
      end
      psclk_pkg::PS_IDLE, psclk_pkg::PS_SLEEP:
      begin
        if (irq_pending || wdt_timeout)
        begin
          st_nxt   = psclk_pkg::PS_RUN;
          wake_nxt = irq_pending;
        end
      end
      default: st_nxt = psclk_pkg::PS_RUN;
    endcase
    // One instruction cycle before disable takes effect
    moddis_eff_nxt = moddis_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clock_divider_register_r     <= psclk_pkg::CLOCK_DIVIDER_REGISTER_RST;
      moddis_r     <= '0;
      moddis_eff_r <= '0;
      st_r         <= psclk_pkg::PS_RUN;
      wdt_clr_r    <= 1'b0;
      wake_r       <= 1'b0;
      full_speed_r <= 1'b0;
      aw_hold_r    <= 1'b0;
      awaddr_r     <= 8'h00;
      w_hold_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      bvalid_r     <= 1'b0;
      bresp_r      <= 2'h0;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= 2'h0;
    end
    else
    begin
      clock_divider_register_r     <= clock_divider_register_nxt;
      moddis_r     <= moddis_nxt;
      moddis_eff_r <= moddis_eff_nxt;
      st_r         <= st_nxt;
      wdt_clr_r    <= wdt_clr_nxt;
      wake_r       <= wake_nxt;
      full_speed_r <= full_speed_nxt;
      aw_hold_r    <= aw_hold_nxt;
      awaddr_r     <= awaddr_nxt;
      w_hold_r     <= w_hold_nxt;
      wdata_r      <= wdata_nxt;
      wstrb_r      <= wstrb_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow CPU enable divider
  assign slow_active = clock_divider_register_r[psclk_pkg::SLOW_EN_BIT] && !full_speed_r;

  psclk_doze_div u_div
  (
    .clk    (clk),
    .rst    (rst),
    .ratio  (clock_divider_register_r[psclk_pkg::RATIO_HI:psclk_pkg::RATIO_LO]),
    .active (slow_active),
    .cpu_en (doze_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock gate outputs
  always_comb
  begin
    gates.cpu_clk_en    = (st_r == psclk_pkg::PS_RUN) && doze_en;
    gates.sys_osc_en    = (st_r != psclk_pkg::PS_SLEEP);
    gates.low_power_rc_oscillator_en       = wdt_enabled
                          || (failsafe_clock_monitor_enabled && st_r != psclk_pkg::PS_SLEEP);
    gates.periph_clk_en = (st_r == psclk_pkg::PS_SLEEP) ? '0
                          : (~moddis_eff_r & periph_present);
  end

  // Register access blocked for disabled modules
  assign periph_access_en = ~moddis_eff_r & periph_present & periph_wr_req | 
                            (~moddis_eff_r & periph_present & ~periph_wr_req);

  assign wdt_clear     = wdt_clr_r;
  assign irq_wake      = wake_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule // psclk_ctrl

//--- psclk_cpu_model.sv
`timescale 1ns/1ps
// Stand-in for the CPU core: counts the clock ticks it is granted
module psclk_cpu_model
(
  input  wire logic        clk,
  input  wire logic        cpu_clk_en,
  input  wire logic        clr,
  output logic      [31:0] cnt_r
);
  // One tick per enabled edge of the shared clock, so counts stay synchronous
  always_ff @(posedge clk)
    if (clr)
      cnt_r <= 32'h0;
    else if (cpu_clk_en)
      cnt_r <= cnt_r + 32'h1;
endmodule  // psclk_cpu_model

//--- psclk_properties.sv
`timescale 1ns/1ps
// Port-level checks of the power-save clock controller
module psclk_properties
(
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          irq_pending,
  input wire logic                          wdt_timeout,
  input wire logic                          wdt_enabled,
  input wire logic                          failsafe_clock_monitor_enabled,
  input wire logic [psclk_pkg::NPERIPH-1:0] periph_present,
  input wire psclk_pkg::psclk_gates_s       gates,
  input wire logic [psclk_pkg::NPERIPH-1:0] periph_access_en,
  input wire logic                          wdt_clear,
  input wire logic                          irq_wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Wake restarts the oscillator on the next cycle; the CPU enable may still be slowed
  sequence wake_s;
    ##1 gates.sys_osc_en;
  endsequence
  sequence entry_s;
    wdt_clear && !irq_pending && !wdt_timeout;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  mod_gate_a: assert property (
    gates.sys_osc_en |-> gates.periph_clk_en == periph_access_en)
    else $error("peripheral clock and access enable differ");
  mod_present_a: assert property ((periph_access_en & ~periph_present) == '0)
    else $error("absent peripheral enabled");
  sleep_stop_a: assert property (
    !gates.sys_osc_en |-> !gates.cpu_clk_en && gates.periph_clk_en == '0)
    else $error("clocks run with oscillator stopped");
  low_power_rc_oscillator_keep_a: assert property (
    (wdt_enabled || failsafe_clock_monitor_enabled) && gates.sys_osc_en |-> gates.low_power_rc_oscillator_en)
    else $error("rc oscillator stopped while needed");
  wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one cycle");
  idle_halt_a: assert property (entry_s |=> !gates.cpu_clk_en)
    else $error("cpu clock runs after entry");
  sleep_wake_a: assert property (
    !gates.sys_osc_en && (irq_pending || wdt_timeout) |-> wake_s)
    else $error("no wake from stopped state");
  wake_pulse_a: assert property ($rose(irq_wake) |=> !irq_wake)
    else $error("wake pulse too long");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule  // psclk_properties

bind psclk_ctrl psclk_properties psclk_properties_i
(
  .clk              (clk),
  .rst              (rst),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_rvalid     (s_axi_rvalid),
  .s_axi_rready     (s_axi_rready),
  .s_axi_rdata      (s_axi_rdata),
  .irq_pending      (irq_pending),
  .wdt_timeout      (wdt_timeout),
  .wdt_enabled      (wdt_enabled),
  .failsafe_clock_monitor_enabled     (failsafe_clock_monitor_enabled),
  .periph_present   (periph_present),
  .gates            (gates),
  .periph_access_en (periph_access_en),
  .wdt_clear        (wdt_clear),
  .irq_wake         (irq_wake)
);

//--- tb.sv
`timescale 1ns/1ps
// Self-checking bench of the power-save clock controller
module tb;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cnt;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq_pending = 0, wdt_timeout = 0, wdt_enabled = 1, failsafe_clock_monitor_enabled = 0;
  logic [15:0] periph_present = 16'hFFFE, periph_wr_req = 16'h00FF, periph_access_en;
  psclk_pkg::psclk_gates_s gates;
  logic wdt_clear, irq_wake;
  int n_fail = 0, cmp_count = 0, n_clr = 0, n_wake = 0;

  psclk_ctrl psclk_ctrl_i
  (
    .clk              (clk),
    .rst              (rst),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .irq_pending      (irq_pending),
    .wdt_timeout      (wdt_timeout),
    .wdt_enabled      (wdt_enabled),
    .failsafe_clock_monitor_enabled     (failsafe_clock_monitor_enabled),
    .periph_present   (periph_present),
    .periph_wr_req    (periph_wr_req),
    .gates            (gates),
    .periph_access_en (periph_access_en),
    .wdt_clear        (wdt_clear),
    .irq_wake         (irq_wake)
  );
  psclk_cpu_model psclk_cpu_model_i
  (
    .clk        (clk),
    .cpu_clk_en (gates.cpu_clk_en),
    .clr        (clr),
    .cnt_r      (cnt)
  );

  // Clock and watchdog
  initial forever #2.5 clk = ~clk;
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  // Pulse counters for watchdog clear and interrupt wake
  always @(posedge clk)
  begin
    if (wdt_clear === 1'b1) n_clr++;
    if (irq_wake === 1'b1) n_wake++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI write: both channels offered, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa | pw)
    begin
      @(negedge clk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      @(posedge clk);
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  // AXI read
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ok = s_axi_arready;
      @(posedge clk);
    end
    while (ok !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Count CPU ticks over 1024 cycles
  task automatic measure(input logic [31:0] exp);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (1024) @(posedge clk);
    @(negedge clk);
    chk(cnt, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    axr(psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER, d, r);
    chk(d, 32'h0);
    axr(psclk_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h7, 32'h1);
    chk(32'(periph_access_en), 32'hFFFE);
    $display("test reset done");
  endtask
  task automatic t_pmd;
    logic [31:0] d;
    logic [1:0] r;
    axw(psclk_pkg::ADDR_MODDIS, 32'h5, r);
    settle(2);
    chk(32'(periph_access_en), 32'hFFFA);
    chk(32'(gates.periph_clk_en), 32'hFFFA);
    axw(psclk_pkg::ADDR_MODDIS, 32'h0, r);
    settle(2);
    chk(32'(periph_access_en), 32'hFFFE);
    axr(8'h10, d, r);
    chk(32'(r), 32'(psclk_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    axw(8'h14, 32'h1, r);
    chk(32'(r), 32'(psclk_pkg::RESP_SLVERR));
    $display("test module disable done");
  endtask
  task automatic t_doze;
    logic [1:0] r;
    for (int k = 0; k < 8; k++)
    begin
      axw(psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h800 | (k << 12), r);
      measure(32'd1024 >> k);
      chk(32'(gates.periph_clk_en), 32'hFFFE);
    end
    axw(psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h3800, r);
    @(posedge clk) irq_pending <= 1'b1;
    measure(32'd128);
    @(posedge clk) irq_pending <= 1'b0;
    axw(psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'hB800, r);
    @(posedge clk) irq_pending <= 1'b1;
    settle(4);
    measure(32'd1024);
    @(posedge clk) irq_pending <= 1'b0;
    axw(psclk_pkg::ADDR_CLOCK_DIVIDER_REGISTER, 32'h3000, r);
    measure(32'd1024);
    $display("test doze done");
  endtask
  task automatic t_idle;
    logic [31:0] d;
    logic [1:0] r;
    int c0, w0;
    c0 = n_clr;
    axw(psclk_pkg::ADDR_PSCTRL, 32'h2, r);
    settle(3);
    chk(32'(n_clr - c0), 32'h1);
    chk(32'(gates.cpu_clk_en), 32'h0);
    chk(32'(gates.sys_osc_en), 32'h1);
    chk(32'(gates.periph_clk_en), 32'hFFFE);
    chk(32'(gates.low_power_rc_oscillator_en), 32'h1);
    axr(psclk_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h7, 32'h2);
    // Monitor alone must keep the RC oscillator running
    @(posedge clk) {wdt_enabled, failsafe_clock_monitor_enabled} <= 2'h1;
    settle(1);
    chk(32'(gates.low_power_rc_oscillator_en), 32'h1);
    @(posedge clk) {wdt_enabled, failsafe_clock_monitor_enabled} <= 2'h2;
    w0 = n_wake;
    @(posedge clk) irq_pending <= 1'b1;
    settle(4);
    chk(32'(gates.cpu_clk_en), 32'h1);
    chk(32'(n_wake - w0), 32'h1);
    axw(psclk_pkg::ADDR_PSCTRL, 32'h2, r);
    settle(4);
    chk(32'(n_clr - c0), 32'h2);
    chk(32'(gates.cpu_clk_en), 32'h1);
    @(posedge clk) irq_pending <= 1'b0;
    $display("test idle done");
  endtask
  task automatic t_sleep;
    logic [1:0] r;
    axw(psclk_pkg::ADDR_PSCTRL, 32'h1, r);
    settle(3);
    chk(32'(gates.sys_osc_en), 32'h0);
    chk(32'(gates.cpu_clk_en), 32'h0);
    chk(32'(gates.periph_clk_en), 32'h0);
    @(posedge clk) wdt_timeout <= 1'b1;
    @(posedge clk) wdt_timeout <= 1'b0;
    settle(4);
    chk(32'(gates.sys_osc_en), 32'h1);
    axw(psclk_pkg::ADDR_PSCTRL, 32'h3, r);
    settle(3);
    chk(32'(gates.sys_osc_en), 32'h0);
    @(posedge clk) irq_pending <= 1'b1;
    settle(4);
    chk(32'(gates.cpu_clk_en), 32'h1);
    @(posedge clk) irq_pending <= 1'b0;
    axw(psclk_pkg::ADDR_PSCTRL, 32'h1, r);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    settle(1);
    chk(32'(gates.cpu_clk_en), 32'h1);
    $display("test sleep done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_pmd;
    t_doze;
    t_idle;
    t_sleep;
    tally_and_finish;
  end
endmodule  // tb
